// >>> hdl/hpi_regs.vh
// Constants for the host processor port: reset values, serial frame, states.
`ifndef HPI_REGS_VH
`define HPI_REGS_VH
`define HPI_SYNC_W        26
`define HPI_SYNC_RST      26'h0000000
`define HPI_ADDR_RST      11'h000
`define HPI_DATA_RST      8'h00
`define HPI_SER_CNT_RST   5'h00
`define HPI_SER_CMD_LAST  5'h0B
`define HPI_SER_FRM_LAST  5'h13
`define HPI_SER_FRM_BITS  5'h14
`define HPI_ST_IDLE       2'h0
`define HPI_ST_RD_WAIT    2'h1
`define HPI_ST_HOLD       2'h2
`endif

// >>> hdl/hpi_sync.v
// Two flip-flop synchroniser for a vector of asynchronous inputs.
`timescale 1ns/1ns
module hpi_sync #(
    parameter W = 1
) (
    input  wire         clk,
    input  wire         rst_sync_n,
    input  wire [W-1:0] din,
    output reg  [W-1:0] dout
);
    reg [W-1:0] stage1;

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            stage1 <= {W{1'b0}};
            dout   <= {W{1'b0}};
        end else begin
            stage1 <= din;
            dout   <= stage1;
        end
    end
endmodule // hpi_sync

// >>> hdl/hpi_host_port.v
// Host processor port: two parallel bus styles and a four-wire serial mode.
`timescale 1ns/1ns
`include "hpi_regs.vh"
module hpi_host_port (
    input  wire        clk,
    input  wire        rst_n,
    input  wire        port_type_select,
    input  wire        parallel_style_select,
    input  wire        bus_multiplex_select,
    input  wire        chip_select_n,
    input  wire        dirstyle_addr_strobe,
    input  wire        data_strobe_n,
    input  wire        serial_in_line,
    input  wire [10:0] addr,
    input  wire [7:0]  data_in,
    output wire        serial_out_line,
    output reg  [7:0]  data_out,
    output wire        data_oe_n,
    output reg  [10:0] reg_addr,
    output reg  [7:0]  reg_wdata,
    output reg         reg_wr,
    output reg         reg_rd,
    input  wire [7:0]  reg_rdata
);
    reg         rst_s1;
    reg         rst_sync_n;
    wire [25:0] s_in;
    reg         p_alat;
    reg         p_strb;
    reg         p_sin;
    reg  [1:0]  state;
    reg         is_read;
    reg         drive;
    reg         wr_late;
    reg  [7:0]  wr_hold;
    reg  [10:0] lat_addr;
    reg  [4:0]  ser_cnt;
    reg  [18:0] ser_shift;
    reg         ser_read;
    reg         ser_load;
    reg  [7:0]  ser_out;
    reg         sout_bit;

    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rst_s1     <= 1'b0;
            rst_sync_n <= 1'b0;
        end else begin
            rst_s1     <= 1'b1;
            rst_sync_n <= rst_s1;
        end
    end

    hpi_sync #(.W(`HPI_SYNC_W)) u_sync (
        .clk        (clk),
        .rst_sync_n (rst_sync_n),
        .din        ({port_type_select, parallel_style_select,
                      bus_multiplex_select, chip_select_n,
                      dirstyle_addr_strobe, data_strobe_n,
                      serial_in_line, addr, data_in}),
        .dout       (s_in)
    );

    wire        s_ptype = s_in[25];
    wire        s_style = s_in[24];
    wire        s_mux   = s_in[23];
    wire        s_cs_n  = s_in[22];
    wire        s_alat  = s_in[21];
    wire        s_strb  = s_in[20];
    wire        s_sin   = s_in[19];
    wire [10:0] s_a     = s_in[18:8];
    wire [7:0]  s_d     = s_in[7:0];

    wire serial    = ~s_ptype;
    wire dstr_sty  = s_ptype & ~s_style;
    wire pair_sty  = s_ptype & s_style;
    wire strb_fall = p_strb & ~s_strb;
    wire strb_rise = ~p_strb & s_strb;
    wire alat_fall = p_alat & ~s_alat;
    wire wr_fall   = p_sin & ~s_sin;
    wire selected  = ~s_cs_n;

    // A read in the data-strobe style is a strobe fall with direction high.
    wire start_rd = selected & strb_fall
                  & (pair_sty | (dstr_sty & s_sin));
    wire start_wr = selected & ((pair_sty & wr_fall)
                              | (dstr_sty & strb_fall & ~s_sin));
    // Muxed: low byte came from the data pins at the address strobe fall.
    wire [10:0] cur_addr = s_mux ? {s_a[10:8], lat_addr[7:0]}
                                 : s_a;
    // The transfer ends when its strobe returns high or chip select rises.
    wire strobe_up = (pair_sty & ~is_read) ? s_sin : s_strb;
    wire xfer_end  = s_cs_n | strobe_up;

    wire [11:0] ser_cmd = {ser_shift[10:0], s_sin};
    wire [7:0]  ser_dat = {ser_shift[6:0], s_sin};

    always @(posedge clk or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            p_alat    <= 1'b0;
            p_strb    <= 1'b0;
            p_sin     <= 1'b0;
            state     <= `HPI_ST_IDLE;
            is_read   <= 1'b0;
            drive     <= 1'b0;
            wr_late   <= 1'b0;
            wr_hold   <= `HPI_DATA_RST;
            lat_addr  <= `HPI_ADDR_RST;
            data_out  <= `HPI_DATA_RST;
            reg_addr  <= `HPI_ADDR_RST;
            reg_wdata <= `HPI_DATA_RST;
            reg_wr    <= 1'b0;
            reg_rd    <= 1'b0;
            ser_cnt   <= `HPI_SER_CNT_RST;
            ser_shift <= 19'h00000;
            ser_read  <= 1'b0;
            ser_load  <= 1'b0;
            ser_out   <= `HPI_DATA_RST;
            sout_bit  <= 1'b0;
        end else begin
            p_alat   <= s_alat;
            p_strb   <= s_strb;
            p_sin    <= s_sin;
            reg_wr   <= 1'b0;
            reg_rd   <= 1'b0;
            ser_load <= 1'b0;
            if (s_ptype && s_mux && alat_fall) begin
                lat_addr <= {s_a[10:8], s_d};
            end
            if (serial) begin
                state <= `HPI_ST_IDLE;
                drive <= 1'b0;
                if (s_cs_n) begin
                    ser_cnt <= `HPI_SER_CNT_RST;
                end else if (strb_rise && ser_cnt != `HPI_SER_FRM_BITS) begin
                    ser_shift <= {ser_shift[17:0], s_sin};
                    ser_cnt   <= ser_cnt + 5'h01;
                    if (ser_cnt == `HPI_SER_CMD_LAST) begin
                        ser_read <= ser_cmd[11];
                        reg_addr <= ser_cmd[10:0];
                        reg_rd   <= ser_cmd[11];
                        ser_load <= ser_cmd[11];
                    end
                    if (ser_cnt == `HPI_SER_FRM_LAST && !ser_read) begin
                        reg_wdata <= ser_dat;
                        reg_wr    <= 1'b1;
                    end
                end else if (strb_fall && ser_read
                             && ser_cnt > `HPI_SER_CMD_LAST) begin
                    sout_bit <= ser_out[7];
                    ser_out <= {ser_out[6:0], 1'b0};
                end
                if (ser_load) begin
                    ser_out <= reg_rdata;
                end
            end else begin
                case (state)
                    `HPI_ST_IDLE: begin
                        if (start_rd) begin
                            reg_addr <= cur_addr;
                            reg_rd   <= 1'b1;
                            is_read  <= 1'b1;
                            drive    <= 1'b1;
                            state    <= `HPI_ST_RD_WAIT;
                        end else if (start_wr) begin
                            reg_addr  <= cur_addr;
                            is_read   <= 1'b0;
                            state     <= `HPI_ST_HOLD;
                            // Strobe-pair data may settle late, so it is
                            // written at the strobe's rise.
                            wr_late   <= pair_sty;
                            wr_hold   <= s_d;
                            reg_wdata <= s_d;
                            reg_wr    <= dstr_sty;
                        end
                    end
                    `HPI_ST_RD_WAIT: begin
                        data_out <= reg_rdata;
                        state    <= `HPI_ST_HOLD;
                    end
                    `HPI_ST_HOLD: begin
                        if (wr_late) begin
                            wr_hold <= s_d;
                        end
                        if (xfer_end) begin
                            state   <= `HPI_ST_IDLE;
                            drive   <= 1'b0;
                            wr_late <= 1'b0;
                            if (wr_late) begin
                                reg_wdata <= wr_hold;
                                reg_wr    <= 1'b1;
                            end
                        end
                    end
                    default: begin
                        state <= `HPI_ST_IDLE;
                        drive <= 1'b0;
                    end
                endcase
            end
        end
    end

    // Ready falls only while read data is fetched; writes never wait.
    wire rdy   = (state != `HPI_ST_RD_WAIT);
    wire ack_n = (state != `HPI_ST_HOLD);

    assign serial_out_line = serial ? sout_bit : (dstr_sty ? ack_n : rdy);
    assign data_oe_n       = ~(drive & ~serial);
endmodule // hpi_host_port

// >>> testbench/hpi_host_port_properties.sv
// Concurrent checks on the pins of the host processor port.
`timescale 1ns/1ns
module hpi_props (
    input wire       clk,
    input wire       rst_n,
    input wire       port_type_select,
    input wire       parallel_style_select,
    input wire       data_strobe_n,
    input wire [7:0] data_in,
    input wire       serial_out_line,
    input wire [7:0] data_out,
    input wire       data_oe_n,
    input wire [7:0] reg_wdata,
    input wire       reg_wr,
    input wire       reg_rd,
    input wire [7:0] reg_rdata
);
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    wire pa  = port_type_select;
    wire dsm = pa && !parallel_style_select;
    wire spm = pa && parallel_style_select;
    a_wr_float: assert property (reg_wr |-> data_oe_n)
        else $error("data pins driven during a write");
    a_rd_data: assert property (
        pa && reg_rd |-> ##2 data_out == reg_rdata)
        else $error("read data not presented");
    a_ack_low: assert property (
        dsm && (reg_rd || reg_wr) |-> ##[0:3] !serial_out_line)
        else $error("acknowledge missing");
    a_rdy_wait: assert property (
        spm && reg_rd |-> !serial_out_line ##1 serial_out_line)
        else $error("ready wait state wrong");
    a_wdata_take: assert property (
        pa && reg_wr |-> reg_wdata == data_in)
        else $error("write data not taken from pins");
    a_oe_release: assert property (
        pa && $rose(data_strobe_n) |-> ##[0:5] data_oe_n)
        else $error("data pins not released");
    a_ser_float: assert property (!pa |-> data_oe_n)
        else $error("data pins driven in serial mode");
    a_sout_fall: assert property (
        !pa && $past(!pa, 4) && $changed(serial_out_line)
        |-> !$past(data_strobe_n, 3))
        else $error("serial output moved off a falling shift edge");
    c_strb_read: cover property (dsm && reg_rd);
    c_sp_write: cover property (spm && reg_wr);
    c_ser_read: cover property (!pa && reg_rd);
endmodule // hpi_props
bind hpi_host_port hpi_props u_props (.clk(clk), .rst_n(rst_n),
    .port_type_select(port_type_select),
    .parallel_style_select(parallel_style_select),
    .data_strobe_n(data_strobe_n), .data_in(data_in),
    .serial_out_line(serial_out_line), .data_out(data_out),
    .data_oe_n(data_oe_n), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata));

// >>> testbench/hpi_host_model.sv
// Behavioural host processor driving the port pins.
`timescale 1ns/1ns
module hpi_host_model (
    input  wire        clk,
    input  wire        sol,
    input  wire        oe_n,
    input  wire [7:0]  dout,
    output wire [7:0]  din,
    output reg         pt,
    output reg         sty,
    output reg         mux,
    output reg         cs_n,
    output reg         alat,
    output reg         strb_n,
    output reg         sin,
    output reg  [10:0] a
);
    reg [7:0] hd;
    reg       hdrv;
    integer   i;
    // Two drivers at once show as unknown, so contention cannot pass.
    assign din = !oe_n ? (hdrv ? 8'hXX : dout) : hd;
    task mode(input p, input s, input m);
        begin
            pt = p;
            sty = s | !p;
            mux = m & p;
            cs_n = 1'b1;
            alat = p & !m;
            strb_n = p;
            sin = p;
            a = 11'h000;
            hd = 8'h00;
            hdrv = 1'b1;
        end
    endtask
    task xfer(input rd, input [10:0] ad, input [7:0] d, output [7:0] q);
        begin
            cs_n = 1'b0;
            q = 8'h00;
            if (!pt) begin
                for (i = 0; i < 20; i = i + 1) begin
                    sin = i == 0 ? rd : i < 12 ? ad[11-i] : d[19-i];
                    repeat (4) @(negedge clk);
                    strb_n = 1'b1;
                    if (i > 11) q = {q[6:0], sol};
                    repeat (4) @(negedge clk);
                    strb_n = 1'b0;
                end
            end else begin
                a = mux ? {ad[10:8], 8'h00} : ad;
                if (mux) begin
                    hd = ad[7:0];
                    alat = 1'b1;
                    repeat (4) @(negedge clk);
                    alat = 1'b0;
                    repeat (4) @(negedge clk);
                end
                hdrv = !rd;
                hd = rd ? ~hd : d;
                // Direction and write strobe share a pin: high reads.
                sin = rd;
                strb_n = sty & !rd;
                for (i = 0; i < 30; i = i + 1) begin
                    @(posedge clk);
                    if (sty ? (rd ? sol && !oe_n : i > 5) : !sol) i = 30;
                end
                q = din;
                @(negedge clk);
                strb_n = 1'b1;
                sin = 1'b1;
                repeat (6) @(negedge clk);
            end
            cs_n = 1'b1;
            hdrv = !pt;
            if (pt) hd = ~hd;
            repeat (6) @(negedge clk);
        end
    endtask
endmodule // hpi_host_model

// >>> testbench/tb_host_processor_interface.sv
// Self-checking bench for the host processor port.
`timescale 1ns/1ns
module tb_host_processor_interface;
    reg         clk = 1'b0;
    reg         rst_n = 1'b0;
    wire        pt, sty, mux, cs_n, alat, strb_n, sin, sol, oe_n, rd, wr;
    wire [10:0] a, ra;
    wire [7:0]  din, dout, wd;
    integer     fails = 0, checked = 0, cyc = 0, n, wseen, m;
    reg  [31:0] r;
    reg  [10:0] ea;
    reg  [7:0]  ed, q;
    always #50 clk = ~clk;
    function [7:0] rdv(input [10:0] x);
        rdv = x[7:0] ^ {x[10:8], x[10:6]};
    endfunction
    hpi_host_port i_dut (.clk(clk), .rst_n(rst_n), .port_type_select(pt),
        .parallel_style_select(sty), .bus_multiplex_select(mux),
        .chip_select_n(cs_n), .dirstyle_addr_strobe(alat),
        .data_strobe_n(strb_n), .serial_in_line(sin), .addr(a),
        .data_in(din), .serial_out_line(sol), .data_out(dout),
        .data_oe_n(oe_n), .reg_addr(ra), .reg_wdata(wd), .reg_wr(wr),
        .reg_rd(rd), .reg_rdata(rdv(ra)));
    hpi_host_model i_host (.clk(clk), .sol(sol), .oe_n(oe_n), .dout(dout),
        .din(din), .pt(pt), .sty(sty), .mux(mux), .cs_n(cs_n), .alat(alat),
        .strb_n(strb_n), .sin(sin), .a(a));
    task chk(input ok, input [95:0] s);
        begin
            checked = checked + 1;
            if (!ok) begin
                fails = fails + 1;
                $display("CHECK FAILED at %0t: %0s", $time, s);
            end
        end
    endtask
    task end_sim;
        begin
            $display("checked %0d fails %0d", checked, fails);
            if (fails == 0 && checked > 0)
                $display("Result: passed");
            else
                $display("Result: failed");
            $finish;
        end
    endtask
    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 30000) begin
            fails = fails + 1;
            end_sim;
        end
        if (wr) begin
            wseen = wseen + 1;
            chk(ra === ea && wd === ed, "write");
        end
    end
    task run(input p, input s, input mm);
        integer k;
        begin
            rst_n = 1'b0;
            i_host.mode(p, s, mm);
            repeat (2) @(negedge clk);
            rst_n = 1'b1;
            repeat (6) @(negedge clk);
            for (k = 0; k < 8; k = k + 1) begin
                r = $urandom;
                ea = k < 2 ? {11{k[0]}} : r[10:0];
                ed = r[18:11];
                wseen = 0;
                i_host.xfer(k[0], ea, ed, q);
                if (k[0])
                    chk(q === rdv(ea), "read");
                else chk(wseen === 1, "write count");
            end
            $display("test pt=%0d st=%0d mx=%0d done", p, s, mm);
        end
    endtask
    initial begin
        m = $urandom(32'h14e44446);
        run(1'b0, 1'b1, 1'b0);
        for (n = 0; n < 4; n = n + 1) run(1'b1, n[1], n[0]);
        end_sim;
    end
endmodule // tb_host_processor_interface
